// file: rtl/i2c_host_pkg.sv
// Shared constants and state encodings for the I2C host sequencer.
package i2c_host_pkg;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int          BRG_WIDTH     = 8;      // Reload value width
  localparam int          BYTE_BITS     = 8;      // Bits in one byte
  localparam logic [3:0]  BIT_ACK       = 4'h8;   // Index of the ninth clock
  localparam logic [3:0]  BIT_LAST_DATA = 4'h7;   // Index of the eighth clock
  localparam logic [7:0]  BUFFER_RESET  = 8'h00;  // Buffer value after reset
  localparam logic [3:0]  BIT_RESET     = 4'h0;   // Bit counter after reset

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,  // Waiting for a command
    ST_ACK_LOW   = 4'b0001,  // Acknowledge: SCL low, data on SDA
    ST_ACK_WAIT  = 4'b0010,  // Acknowledge: SCL released, waiting high
    ST_ACK_HIGH  = 4'b0011,  // Acknowledge: SCL high period
    ST_STP_SDA   = 4'b0100,  // Stop: SDA pulled low, waiting for it
    ST_STP_CNT   = 4'b0101,  // Stop: SCL low count
    ST_STP_SCLW  = 4'b0110,  // Stop: SCL released, waiting high
    ST_STP_SCLH  = 4'b0111,  // Stop: SCL high, SDA still low
    ST_STP_SDAW  = 4'b1000,  // Stop: SDA released, waiting high
    ST_STP_END   = 4'b1001,  // Stop: final period before completion
    ST_TX_LOW    = 4'b1010,  // Transmit: SCL low, bit on SDA
    ST_TX_WAIT   = 4'b1011,  // Transmit: SCL released, waiting high
    ST_TX_HIGH   = 4'b1100   // Transmit: SCL high period
  } seq_state_type;

endpackage : i2c_host_pkg

// file: rtl/brg_counter.sv
// Baud rate generator: reloadable down counter giving one tick per period.
`timescale 1ns/10ps
module brg_counter #(
  parameter int WIDTH = 8                 // Reload value width
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             nrst,     // Synchronous reset, active low
  input  wire logic             clk_en,   // Freezes the counter while low
  input  wire logic             load,     // Restart from the reload value
  input  wire logic             run,      // Count while high
  input  wire logic [WIDTH-1:0] reload,   // Reload value
  output logic                  tick      // Period elapsed, one cycle
);

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] count;                // Remaining cycles in period

  initial begin
    if (WIDTH < 1) begin
      $error("brg_counter needs WIDTH of at least one");
    end
  end

  // A period lasts reload + 1 cycles, so a zero reload still ticks
  assign tick = run && !load && (count == '0);

  // Load wins over counting so every restart begins a full period
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count <= '0;
    end else if (clk_en) begin
      if (load) begin
        count <= reload;
      end else if (run) begin
        count <= (count == '0) ? reload : count - 1'b1;
      end
    end
  end

endmodule : brg_counter

// file: rtl/od_pin.sv
// Open-drain pin cell: registered pull-low drive and registered sampling.
`timescale 1ns/10ps
module od_pin (
  input  wire logic clk_sys,     // System clock
  input  wire logic nrst,        // Synchronous reset, active low
  input  wire logic clk_en,      // Freezes the cell while low
  input  wire logic drive_low,   // Request to pull the line low
  input  wire logic pin_in,      // Actual line level
  output logic      pin_out,     // Level driven while enabled, always 0
  output logic      pin_oe,      // High while the cell pulls the line
  output logic      level        // Sampled line level
);

  // ---------------------------------------------------------------
  // Drive and sample
  // ---------------------------------------------------------------
  // The cell never drives high; the pull-up makes the high level
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
      level   <= 1'b1;
    end else if (clk_en) begin
      pin_out <= 1'b0;
      pin_oe  <= drive_low;
      level   <= pin_in;
    end
  end

endmodule : od_pin

// file: rtl/i2c_host_ack_stop_transmit.sv
// I2C host sequencer: acknowledge, stop condition and byte transmission.
`timescale 1ns/10ps
// How it works
// [RL1] Acknowledge enable pulls SCL, presents ack data
// [RL2] Software picks ACK or NACK beforehand
// [RL3] Ack: low period, high period, self-clear
// [RL4] Buffer write during ack flags collision
// [RL5] SCL stays low after each byte
// [RL6] Stop: SDA low, count, release SCL
// [RL7] SDA released later; high sets stop-detected
// [RL8] Period later: clear stop enable, interrupt
// [RL9] Buffer write during stop flags collision
// [RL10] Reset disables module, abandons transfer
// [RL11] Buffer write sets full, starts generator
// [RL12] Bit on SDA, SCL low, high periods
// [RL13] Eighth fall clears full, releases SDA
// [RL14] Ninth clock captures client acknowledge
// [RL15] After ninth clock: interrupt, SCL held
// [RL16] Buffer write mid-byte flags collision
// [RL17] Software clears collision before next byte
// [RL18] Address bits then R/W, MSB first
// [RL19] Software sends R/W zero when transmitting
// [RL20] Stop completion raises serial interrupt
// [RL21] Generator restarts from programmed reload value
// [RL22] Lines open-drain; checks use pin levels
module i2c_host_ack_stop_transmit
  import i2c_host_pkg::*;
#(
  parameter int BRG_W = i2c_host_pkg::BRG_WIDTH      // Reload value width
) (
  input  wire logic             clk_sys,             // System clock, 200 MHz
  input  wire logic             nrst,                // Synchronous reset
  input  wire logic             clk_en,              // Freezes all state
  input  wire logic             module_enable,       // Serial module enable
  input  wire logic [BRG_W-1:0] brg_reload_value,    // Generator reload
  input  wire logic             ack_seq_start,       // Set ack enable, pulse
  input  wire logic             ack_data_value,      // 0 = ACK, 1 = NACK
  input  wire logic             stop_start,          // Set stop enable, pulse
  input  wire logic             buf_write,           // Buffer write strobe
  input  wire logic [7:0]       buf_wdata,           // Buffer write data
  input  wire logic             write_collision_clear,          // Clear collision, pulse
  input  wire logic             irq_clear,           // Clear interrupt, pulse
  input  wire logic             scl_in,              // SCL line level
  input  wire logic             sda_in,              // SDA line level
  output logic                  scl_out,             // SCL drive value
  output logic                  scl_oe,              // SCL pulled low
  output logic                  sda_out,             // SDA drive value
  output logic                  sda_oe,              // SDA pulled low
  output logic                  ack_seq_enable,      // Acknowledge running
  output logic                  stop_enable,         // Stop running
  output logic [7:0]            tx_rx_buffer,        // Buffer contents
  output logic                  buffer_full,         // Byte pending
  output logic                  write_collision,     // Rejected write
  output logic                  ack_status,          // 1 = NACK received
  output logic                  stop_detected,       // Stop seen on bus
  output logic                  serial_irq_flag,     // Sequence finished
  output logic                  busy                 // Sequencer not idle
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  seq_state_type state;              // Sequencer state
  logic [7:0]    shift_register;     // Bits still to shift out
  logic [3:0]    bit_cnt;            // Clock index within a byte
  logic          scl_hold;           // Keep SCL low while idle
  logic          scl_level;          // Sampled SCL
  logic          sda_level;          // Sampled SDA
  logic          brg_load;           // Restart the generator
  logic          brg_run;            // Generator counting
  logic          brg_tick;           // Generator period elapsed
  logic          next_scl_low;       // SCL pull request
  logic          next_sda_low;       // SDA pull request
  logic          idle;               // Accepting commands
  logic          wr_ok;              // Buffer write accepted

  initial begin
    if (BRG_W < 1 || BRG_W > 16) begin
      $error("BRG_W must lie between 1 and 16");
    end
  end

  assign idle  = (state == ST_IDLE) && module_enable;
  // Ack and stop requests take the cycle; a write beside them collides
  assign wr_ok = buf_write && idle && !ack_seq_start && !stop_start;

  // ---------------------------------------------------------------
  // Generator control
  // ---------------------------------------------------------------
  // Every restart reloads from software's value [RL21]
  always_comb begin
    brg_load = 1'b0;
    brg_run  = 1'b0;
    unique case (state)
      ST_IDLE: begin
        brg_load = idle && (ack_seq_start || stop_start || buf_write);
      end
      ST_ACK_WAIT: begin
        brg_load = scl_level;                   // [RL3]
      end
      ST_STP_SDA: begin
        brg_load = !sda_level;                  // [RL6]
      end
      ST_STP_SCLW: begin
        brg_load = scl_level;                   // [RL7]
      end
      ST_STP_SDAW: begin
        brg_load = sda_level && scl_level;      // [RL7]
      end
      ST_TX_WAIT: begin
        brg_load = scl_level;                   // [RL12]
      end
      default: begin
        brg_run = 1'b1;
      end
    endcase
  end

  brg_counter #(
    .WIDTH (BRG_W)
  ) u_brg (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .load    (brg_load),
    .run     (brg_run),
    .reload  (brg_reload_value),
    .tick    (brg_tick)
  );

  // ---------------------------------------------------------------
  // Line drive requests
  // ---------------------------------------------------------------
  // Only pulls low or releases; the pull-up provides high [RL22]
  always_comb begin
    next_scl_low = 1'b0;
    next_sda_low = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_scl_low = scl_hold;                                    // [RL5]
        // After an ack, SDA stays put until SCL is seen low (hold time)
        next_sda_low = scl_hold && scl_level && sda_oe;
      end
      ST_ACK_LOW: begin
        next_scl_low = 1'b1;                                        // [RL1]
        next_sda_low = !ack_data_value;                             // [RL1]
      end
      ST_ACK_WAIT, ST_ACK_HIGH: next_sda_low = !ack_data_value;
      ST_STP_SDA, ST_STP_CNT: begin
        next_scl_low = 1'b1;
        next_sda_low = 1'b1;                                        // [RL6]
      end
      ST_STP_SCLW, ST_STP_SCLH: next_sda_low = 1'b1;
      ST_STP_SDAW, ST_STP_END: next_sda_low = 1'b0;                 // [RL7]
      ST_TX_LOW: begin
        next_scl_low = 1'b1;                                        // [RL12]
        // Old bit holds until SCL is seen low; ninth frees SDA [RL13]
        next_sda_low = scl_level ? sda_oe : (bit_cnt != BIT_ACK) && !shift_register[7]; // [RL18]
      end
      ST_TX_WAIT, ST_TX_HIGH: begin
        next_sda_low = (bit_cnt != BIT_ACK) && !shift_register[7];
      end
      default: next_scl_low = 1'b0;
    endcase
  end

  od_pin u_scl (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .drive_low (next_scl_low),
    .pin_in    (scl_in),
    .pin_out   (scl_out),
    .pin_oe    (scl_oe),
    .level     (scl_level)
  );

  od_pin u_sda (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .drive_low (next_sda_low),
    .pin_in    (sda_in),
    .pin_out   (sda_out),
    .pin_oe    (sda_oe),
    .level     (sda_level)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Reset or disable drops back to idle with both lines free [RL10]
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state    <= ST_IDLE;                                       // [RL10]
      bit_cnt  <= BIT_RESET;
      scl_hold <= 1'b0;
    end else if (clk_en) begin
      if (!module_enable) begin
        state    <= ST_IDLE;                                     // [RL10]
        scl_hold <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (ack_seq_start) state <= ST_ACK_LOW;              // [RL1]
            else if (stop_start) state <= ST_STP_SDA;            // [RL6]
            else if (buf_write) begin
              state   <= ST_TX_LOW;                              // [RL11]
              bit_cnt <= BIT_RESET;
            end
          end
          ST_ACK_LOW:  if (brg_tick) state <= ST_ACK_WAIT;       // [RL3]
          ST_ACK_WAIT: if (scl_level) state <= ST_ACK_HIGH;      // [RL3]
          ST_ACK_HIGH: begin
            if (brg_tick) begin
              state    <= ST_IDLE;                               // [RL3]
              scl_hold <= 1'b1;
            end
          end
          ST_STP_SDA:  if (!sda_level) state <= ST_STP_CNT;      // [RL6]
          ST_STP_CNT:  if (brg_tick) state <= ST_STP_SCLW;       // [RL6]
          ST_STP_SCLW: if (scl_level) state <= ST_STP_SCLH;
          ST_STP_SCLH: if (brg_tick) state <= ST_STP_SDAW;       // [RL7]
          ST_STP_SDAW: if (sda_level && scl_level) state <= ST_STP_END;
          ST_STP_END: begin
            if (brg_tick) begin
              state    <= ST_IDLE;                               // [RL8]
              scl_hold <= 1'b0;
            end
          end
          ST_TX_LOW:   if (brg_tick) state <= ST_TX_WAIT;        // [RL12]
          ST_TX_WAIT:  if (scl_level) state <= ST_TX_HIGH;       // [RL12]
          ST_TX_HIGH: begin
            if (brg_tick) begin
              if (bit_cnt == BIT_ACK) begin
                state    <= ST_IDLE;                             // [RL15]
                scl_hold <= 1'b1;                                // [RL5]
              end else begin
                state   <= ST_TX_LOW;
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Shift register and buffer
  // ---------------------------------------------------------------
  // A refused write leaves buffer and shifter untouched [RL4] [RL9] [RL16]
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_rx_buffer   <= BUFFER_RESET;
      shift_register <= BUFFER_RESET;
    end else if (clk_en) begin
      if (wr_ok) begin
        tx_rx_buffer   <= buf_wdata;
        shift_register <= buf_wdata;                             // [RL18]
      end else if (state == ST_TX_HIGH && brg_tick && bit_cnt != BIT_ACK) begin
        shift_register <= {shift_register[6:0], 1'b0};           // [RL18]
      end
    end
  end

  // ---------------------------------------------------------------
  // Control enables
  // ---------------------------------------------------------------
  // Set by software when idle, cleared by hardware on completion
  always_ff @(posedge clk_sys) begin
    if (!nrst || (clk_en && !module_enable)) begin
      ack_seq_enable <= 1'b0;
      stop_enable    <= 1'b0;
    end else if (clk_en) begin
      if (idle && ack_seq_start) ack_seq_enable <= 1'b1;
      else if (state == ST_ACK_HIGH && brg_tick) ack_seq_enable <= 1'b0;  // [RL3]
      if (idle && stop_start && !ack_seq_start) stop_enable <= 1'b1;
      else if (state == ST_STP_END && brg_tick) stop_enable <= 1'b0;      // [RL8]
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Hardware sets win over software clears so no event is lost
  always_ff @(posedge clk_sys) begin
    if (!nrst || (clk_en && !module_enable)) begin
      buffer_full     <= 1'b0;
      write_collision <= 1'b0;
      ack_status      <= 1'b0;
      stop_detected   <= 1'b0;
      serial_irq_flag <= 1'b0;
      busy            <= 1'b0;
    end else if (clk_en) begin
      busy <= !idle || ack_seq_start || stop_start || buf_write;
      if (wr_ok) buffer_full <= 1'b1;                            // [RL11]
      else if (state == ST_TX_HIGH && brg_tick && bit_cnt == BIT_LAST_DATA) begin
        buffer_full <= 1'b0;                                     // [RL13]
      end
      // Software must clear this before the next byte [RL17]
      if (buf_write && !wr_ok) write_collision <= 1'b1;          // [RL4] [RL9] [RL16]
      else if (write_collision_clear) write_collision <= 1'b0;
      if (state == ST_TX_WAIT && scl_level && bit_cnt == BIT_ACK) begin
        ack_status <= sda_level;                                 // [RL14]
      end
      if (state == ST_STP_SDAW && sda_level && scl_level) stop_detected <= 1'b1;  // [RL7]
      else if (wr_ok) stop_detected <= 1'b0;
      if (brg_tick && ((state == ST_STP_END) || (state == ST_ACK_HIGH)
          || (state == ST_TX_HIGH && bit_cnt == BIT_ACK))) begin
        serial_irq_flag <= 1'b1;                                 // [RL8] [RL15] [RL20]
      end else if (irq_clear) serial_irq_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_WRITE_COLLISION_SET: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL16]
    clk_en && module_enable && buf_write && state != ST_IDLE |=> write_collision)
    else $error("busy buffer write did not flag collision");
  AST_BUF_KEPT: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL9]
    clk_en && buf_write && state != ST_IDLE |=> $stable(tx_rx_buffer))
    else $error("refused write changed the buffer");
  AST_BF_SET: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL11]
    clk_en && wr_ok |=> buffer_full && state == ST_TX_LOW)
    else $error("accepted write did not start a byte");
  AST_BF_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL13]
    $fell(buffer_full) && module_enable |-> state == ST_TX_LOW && bit_cnt == BIT_ACK)
    else $error("buffer full cleared at the wrong clock");
  AST_ACK_SDA: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL1]
    clk_en && state == ST_ACK_LOW ##1 clk_en && state == ST_ACK_LOW
      |-> scl_oe && (sda_oe == !ack_data_value))
    else $error("acknowledge drive wrong");
  AST_ACK_END: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL3]
    $fell(ack_seq_enable) && module_enable |-> state == ST_IDLE && scl_hold)
    else $error("acknowledge ended without holding SCL");
  AST_STOP_IRQ: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL8]
    $fell(stop_enable) && module_enable |-> serial_irq_flag && stop_detected)
    else $error("stop completed without interrupt");
  AST_STOP_DET: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL7]
    $rose(stop_detected) |-> stop_enable && sda_level && scl_level)
    else $error("stop detected outside a stop sequence");
  AST_ACK_STATUS: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL14]
    clk_en && state == ST_TX_WAIT && scl_level && bit_cnt == BIT_ACK && module_enable
      |=> ack_status == $past(sda_level))
    else $error("acknowledge status not captured");
  AST_RESET: assert property (@(posedge clk_sys) // [RL10]
    !nrst |=> state == ST_IDLE && !scl_oe && !sda_oe && !buffer_full)
    else $error("reset left the module active");

  COV_TX_BYTE: cover property (@(posedge clk_sys) disable iff (!nrst)
    state == ST_TX_HIGH && bit_cnt == BIT_ACK ##1 state == ST_IDLE);
  COV_ACK_SEQ: cover property (@(posedge clk_sys) disable iff (!nrst)
    $fell(ack_seq_enable));
  COV_STOP_SEQ: cover property (@(posedge clk_sys) disable iff (!nrst)
    $fell(stop_enable));
  COV_WRITE_COLLISION: cover property (@(posedge clk_sys) disable iff (!nrst)
    $rose(write_collision));

endmodule : i2c_host_ack_stop_transmit

// file: tb/i2c_client_model.sv
// Behavioural I2C client: shifts in bytes and answers ACK or NACK.
`timescale 1ns/10ps
module i2c_client_model (
  input  wire logic       scl,      // Resolved SCL line
  input  wire logic       sda,      // Resolved SDA line
  input  wire logic       nack,     // Answer NACK instead of ACK
  output logic            sda_oe,   // High while pulling SDA low
  output logic [7:0]      rx_byte   // Last byte shifted in
);
  // -------------------------------------------------------------
  // Bit counting on line edges
  // -------------------------------------------------------------
  int bit_cnt = 0;                  // Clocks seen in this byte
  initial sda_oe = 1'b0;
  initial rx_byte = 8'h00;
  // Data is taken while SCL is high, MSB first
  always @(posedge scl) begin
    if (bit_cnt < 8) rx_byte = {rx_byte[6:0], sda};
    bit_cnt = bit_cnt + 1;
  end
  // Drive the ninth bit, then let SDA float back to the pull-up
  always @(negedge scl) begin
    if (bit_cnt == 8) sda_oe = !nack;
    else if (bit_cnt >= 9) begin
      sda_oe = 1'b0;
      bit_cnt = 0;
    end
  end
  // A stop on the wire starts a fresh frame
  always @(posedge sda) if (scl) bit_cnt = 0;
endmodule : i2c_client_model

// file: tb/i2c_host_ack_stop_transmit_tb.sv
// Testbench for the I2C host sequencer: transmit, acknowledge, stop, reset.
`timescale 1ns/10ps
module i2c_host_ack_stop_transmit_tb;
  import i2c_host_pkg::*;
  logic       clk_sys, nrst, ack_seq_start, ack_data_value, stop_start, buf_write;
  logic       write_collision_clear, irq_clear, client_nack, client_oe, module_enable;
  logic [4:0] strobes;  // irq clear, collision clear, stop, ack, write
  logic [7:0] buf_wdata, rx_byte, tx_rx_buffer;
  logic       scl_out, scl_oe, sda_out, sda_oe, ack_seq_enable, stop_enable;
  logic       buffer_full, write_collision, ack_status, stop_detected, serial_irq_flag, busy;
  int         n_errors = 0;
  int         checked = 0;
  // Open-drain wires with pull-ups
  wire logic  scl_line = !scl_oe;
  wire logic  sda_line = !sda_oe && !client_oe;
  assign {irq_clear, write_collision_clear, stop_start, ack_seq_start, buf_write} = strobes;

  i2c_host_ack_stop_transmit u_i2c_host_ack_stop_transmit (.clk_sys(clk_sys), .nrst(nrst),
    .clk_en(1'b1), .module_enable(module_enable), .brg_reload_value(8'h03),
    .ack_seq_start(ack_seq_start), .ack_data_value(ack_data_value), .stop_start(stop_start),
    .buf_write(buf_write), .buf_wdata(buf_wdata), .write_collision_clear(write_collision_clear),
    .irq_clear(irq_clear), .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .ack_seq_enable(ack_seq_enable),
    .stop_enable(stop_enable), .tx_rx_buffer(tx_rx_buffer), .buffer_full(buffer_full),
    .write_collision(write_collision), .ack_status(ack_status),
    .stop_detected(stop_detected), .serial_irq_flag(serial_irq_flag), .busy(busy));
  i2c_client_model u_i2c_client_model (.scl(scl_line), .sda(sda_line), .nack(client_nack),
    .sda_oe(client_oe), .rx_byte(rx_byte));

  // -------------------------------------------------------------
  // Clock, shared tasks and watchdog
  // -------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic test_done;
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // One-cycle strobe: 0 write, 1 ack, 2 stop, 3 clear collision, 4 clear interrupt
  task automatic cmd(input int k, input logic [7:0] d);
    if (k == 0) buf_wdata = d;
    strobes[k] = 1'b1;
    tick(1);
    strobes[k] = 1'b0;
  endtask : cmd
  // Bounded wait for the end-of-sequence flag, which is then checked
  task automatic wait_irq;
    int n;
    n = 0;
    while (serial_irq_flag !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    check(serial_irq_flag, 1'b1);
  endtask : wait_irq
  initial begin
    #20000;
    n_errors++;
    test_done();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    {nrst, ack_data_value, strobes} = 7'h00;
    {client_nack, module_enable} = 2'h1;
    buf_wdata = 8'h00;
    tick(2);
    nrst = 1'b1;
    // Address byte with R/W zero, client acknowledges
    cmd(0, 8'ha4);
    check(buffer_full, 1'b1);
    tick(20);
    cmd(0, 8'h5b);
    check(write_collision, 1'b1);
    check(tx_rx_buffer, 8'ha4);
    wait_irq();
    check(rx_byte, 8'ha4);
    check(ack_status, 1'b0);
    check(buffer_full, 1'b0);
    tick(1);
    check({scl_oe, sda_oe}, 8'h02);
    cmd(3, 8'h00);
    cmd(4, 8'h00);
    // Data byte refused by the client
    client_nack = 1'b1;
    cmd(0, 8'h3c);
    wait_irq();
    check(rx_byte, 8'h3c);
    check(ack_status, 1'b1);
    cmd(4, 8'h00);
    // Acknowledge sequence with ACK data, buffer write collides
    cmd(1, 8'h00);
    check(ack_seq_enable, 1'b1);
    tick(1);
    check({scl_oe, sda_oe}, 8'h03);
    cmd(0, 8'h77);
    check(write_collision, 1'b1);
    check(tx_rx_buffer, 8'h3c);
    wait_irq();
    tick(1);
    check({ack_seq_enable, scl_oe}, 8'h01);
    cmd(3, 8'h00);
    cmd(4, 8'h00);
    // Stop condition with a colliding write
    cmd(2, 8'h00);
    check(stop_enable, 1'b1);
    tick(1);
    check(sda_oe, 1'b1);
    cmd(0, 8'h11);
    check({write_collision, tx_rx_buffer}, 9'h13c);
    wait_irq();
    check({stop_detected, stop_enable}, 8'h02);
    check({scl_line, sda_line}, 8'h03);
    cmd(3, 8'h00);
    cmd(4, 8'h00);
    // Reset in mid-byte abandons the transfer
    cmd(0, 8'hc3);
    tick(15);
    nrst = 1'b0;
    tick(2);
    check({busy, buffer_full, scl_oe, sda_oe}, 8'h00);
    check(tx_rx_buffer, 8'h00);
    // Release in mid-run takes a write at once; disabling abandons it
    nrst = 1'b1;
    cmd(0, 8'h96);
    check(buffer_full, 1'b1);
    tick(10);
    module_enable = 1'b0;
    tick(2);
    check({busy, buffer_full, scl_oe, sda_oe}, 8'h00);
    test_done();
  end
endmodule : i2c_host_ack_stop_transmit_tb
